// ---- src/i2cfr_pkg.sv ----
// i2cfr_pkg: constants and types for the two-wire ferroelectric memory slave
// assumes a single core clock plus the serial clock from the bus master
package i2cfr_pkg;

   // memory geometry
   localparam int unsigned I2CFR_ADDR_W = 15;
   localparam int unsigned I2CFR_MEM_DEPTH = 32768;

   // first byte after a start: type code in bits 7-4
   localparam logic [3:0] I2CFR_TYPE_CODE = 4'ha;
   localparam logic I2CFR_RW_READ = 1'b1;

   // bit counter: 0..7 data bits, 8 is the acknowledge slot
   localparam logic [2:0] I2CFR_LAST_BIT = 3'h7;
   localparam logic [3:0] I2CFR_ACK_SLOT = 4'h8;
   localparam logic [3:0] I2CFR_CNT_RST = 4'h0;

   // identification value, 24 bits; value is arbitrary
   localparam logic [23:0] I2CFR_DEV_ID = 24'h5a3c01;

   // sampled serial lines
   typedef struct packed {
      logic scl;
      logic sda;
   } i2cfr_bus_t;

   localparam i2cfr_bus_t I2CFR_BUS_IDLE = '{scl: 1'b1, sda: 1'b1};

   // protocol phases, one-hot
   typedef enum logic [5:0] {
      ST_DEVADDR = 6'b000001,
      ST_ADDR_HI = 6'b000010,
      ST_ADDR_LO = 6'b000100,
      ST_WDATA = 6'b001000,
      ST_RDATA = 6'b010000,
      ST_IGNORE = 6'b100000
   } i2cfr_state_t;

endpackage

// ---- src/i2cfr_slave.sv ----
// i2cfr_slave: two-wire serial slave front end with a 32k x 8 byte array
// assumes i_scl is driven by the bus master and the sda pad is open drain
`timescale 1ns/1ps
`default_nettype none

module i2cfr_slave
   import i2cfr_pkg::*;
(
   // core clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // serial bus
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda_o,
   output logic o_sda_oe,
   // strap pins
   input wire logic [2:0] i_dev_sel,
   input wire logic i_wp,
   // identification
   output logic [23:0] o_dev_id
);

   // latch increment, wraps from the top address to zero
   function automatic logic [I2CFR_ADDR_W-1:0] addr_inc(input logic [I2CFR_ADDR_W-1:0] a);
      addr_inc = a + 15'h0001;
   endfunction

   function automatic logic dev_match(input logic [7:0] b, input logic [2:0] sel);
      dev_match = (b[7:4] == I2CFR_TYPE_CODE) && (b[3:1] == sel);
   endfunction

   // scl high on both samples while sda moves the asked way
   function automatic logic bus_cond(input i2cfr_bus_t p, input i2cfr_bus_t s,
      input logic sda_rise);
      bus_cond = p.scl & s.scl & (p.sda ^ s.sda) & (s.sda == sda_rise);
   endfunction

   function automatic logic in_ack_slot(input logic [3:0] cnt);
      in_ack_slot = (cnt == I2CFR_ACK_SLOT);
   endfunction

   function automatic logic is_read(input i2cfr_state_t st);
      is_read = (st == ST_RDATA);
   endfunction

   // core domain: start and stop detection
   i2cfr_bus_t bus_m_q;
   i2cfr_bus_t bus_s_q;
   i2cfr_bus_t bus_p_q;
   logic link_rst_q;
   logic link_rst_d;
   logic arm_q;
   logic arm_d;
   logic start_det;
   logic stop_det;
   logic [23:0] dev_id_q;

   always_comb begin
      start_det = bus_cond(bus_p_q, bus_s_q, 1'b0);
      stop_det = bus_cond(bus_p_q, bus_s_q, 1'b1);
      link_rst_d = link_rst_q;
      arm_d = arm_q;
      // release the link logic once the clock is low after a start
      if (arm_q && !bus_s_q.scl) begin
         link_rst_d = 1'b0;
         arm_d = 1'b0;
      end
      // a start or stop always wins over the release
      if (start_det) begin
         link_rst_d = 1'b1;
         arm_d = 1'b1;
      end else if (stop_det) begin
         link_rst_d = 1'b1;
         arm_d = 1'b0;
      end
   end

   // two-flop synchroniser plus one history stage for edge detection
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         bus_m_q <= I2CFR_BUS_IDLE;
         bus_s_q <= I2CFR_BUS_IDLE;
         bus_p_q <= I2CFR_BUS_IDLE;
      end else begin
         bus_m_q <= '{scl: i_scl, sda: i_sda};
         bus_s_q <= bus_m_q;
         bus_p_q <= bus_s_q;
      end
   end

   // link control: held in reset from system reset to the first start
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         link_rst_q <= 1'b1;
         arm_q <= 1'b0;
      end else begin
         link_rst_q <= link_rst_d;
         arm_q <= arm_d;
      end
   end

   // identification value, constant once out of reset
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         dev_id_q <= 24'h000000;
      end else begin
         dev_id_q <= I2CFR_DEV_ID;
      end
   end

   assign o_dev_id = dev_id_q;

   // link domain: strap synchronisers
   logic [2:0] sel_m_q;
   logic [2:0] sel_s_q;
   logic wp_m_q;
   logic wp_s_q;

   // pads pull unconnected straps low, so a floating pin arrives as zero
   always_ff @(posedge i_scl or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         sel_m_q <= 3'h0;
         sel_s_q <= 3'h0;
      end else begin
         sel_m_q <= i_dev_sel;
         sel_s_q <= sel_m_q;
      end
   end

   // write protect follows the same two-flop path
   always_ff @(posedge i_scl or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         wp_m_q <= 1'b0;
         wp_s_q <= 1'b0;
      end else begin
         wp_m_q <= i_wp;
         wp_s_q <= wp_m_q;
      end
   end

   // link domain: byte engine
   // the array is not reset; contents persist across frames
   logic [7:0] mem [0:I2CFR_MEM_DEPTH-1];
   i2cfr_state_t state_q;
   i2cfr_state_t state_d;
   logic [3:0] cnt_q;
   logic [3:0] cnt_d;
   logic [7:0] shift_q;
   logic [7:0] shift_d;
   logic [7:0] rd_q;
   logic [7:0] rd_d;
   logic [6:0] hi_q;
   logic [6:0] hi_d;
   logic ack_q;
   logic ack_d;
   logic [I2CFR_ADDR_W-1:0] addr_q;
   logic [I2CFR_ADDR_W-1:0] addr_d;
   logic [7:0] byte_in;
   logic mem_we;

   always_comb begin
      byte_in = {shift_q[6:0], i_sda};
      state_d = state_q;
      cnt_d = cnt_q;
      shift_d = shift_q;
      rd_d = rd_q;
      hi_d = hi_q;
      ack_d = ack_q;
      addr_d = addr_q;
      mem_we = 1'b0;
      // ack slot: counter wraps, next read byte is fetched
      if (in_ack_slot(cnt_q)) begin
         cnt_d = I2CFR_CNT_RST;
         ack_d = 1'b0;
         if (is_read(state_q)) begin
            // our own ack after the slave address, or the master's ack
            if (ack_q || !i_sda) begin
               rd_d = mem[addr_q];
            end else begin
               state_d = ST_IGNORE;
            end
         end
      end else begin
         // data bit: shift in, act on the eighth
         shift_d = byte_in;
         cnt_d = cnt_q + 4'h1;
         if (cnt_q[2:0] == I2CFR_LAST_BIT) begin
            unique case (state_q)
               ST_DEVADDR: begin
                  if (dev_match(byte_in, sel_s_q)) begin
                     ack_d = 1'b1;
                     state_d = (byte_in[0] == I2CFR_RW_READ) ? ST_RDATA : ST_ADDR_HI;
                  end else begin
                     state_d = ST_IGNORE;
                  end
               end
               ST_ADDR_HI: begin
                  hi_d = byte_in[6:0];
                  ack_d = 1'b1;
                  state_d = ST_ADDR_LO;
               end
               ST_ADDR_LO: begin
                  addr_d = {hi_q, byte_in};
                  ack_d = 1'b1;
                  state_d = ST_WDATA;
               end
               ST_WDATA: begin
                  mem_we = ~wp_s_q;
                  addr_d = addr_inc(addr_q);
                  ack_d = 1'b1;
               end
               ST_RDATA: begin
                  addr_d = addr_inc(addr_q);
               end
               ST_IGNORE: begin
                  ack_d = 1'b0;
               end
            endcase
         end
      end
   end

   always_ff @(posedge i_scl or posedge link_rst_q) begin
      if (link_rst_q) begin
         state_q <= ST_DEVADDR;
         cnt_q <= I2CFR_CNT_RST;
         shift_q <= 8'h00;
         rd_q <= 8'h00;
         hi_q <= 7'h00;
         ack_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         shift_q <= shift_d;
         rd_q <= rd_d;
         hi_q <= hi_d;
         ack_q <= ack_d;
      end
   end

   // the address latch survives frames; only the system reset clears it
   always_ff @(posedge i_scl or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         addr_q <= 15'h0000;
      end else begin
         addr_q <= addr_d;
      end
   end

   // array write lands on the eighth data edge, before the ack slot
   always_ff @(posedge i_scl) begin
      if (mem_we) begin
         mem[addr_q] <= byte_in;
      end
   end

   // link domain: output driver, updated on the falling clock edge
   logic oe_q;
   logic oe_d;

   always_comb begin
      oe_d = 1'b0;
      // read bits leave msb first
      if (in_ack_slot(cnt_q)) begin
         oe_d = ack_q;
      end else if (is_read(state_q)) begin
         oe_d = ~rd_q[I2CFR_LAST_BIT - cnt_q[2:0]];
      end
   end

   always_ff @(negedge i_scl or posedge link_rst_q) begin
      if (link_rst_q) begin
         oe_q <= 1'b0;
      end else begin
         oe_q <= oe_d;
      end
   end

   // open drain: the pad only sinks, the pull-up makes the high
   assign o_sda_o = 1'b0;
   assign o_sda_oe = oe_q;

endmodule

`default_nettype wire

// ---- verification/i2cfr_chk.sv ----
// i2cfr_chk: pin-level assertions for i2cfr_slave
// assumes bus lines change slowly against i_clk
`timescale 1ns/1ps
`default_nettype none
module i2cfr_chk
   import i2cfr_pkg::*;
(
   // watched ports
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_scl,
   input wire logic i_sda,
   input wire logic o_sda_o,
   input wire logic o_sda_oe,
   input wire logic [2:0] i_dev_sel,
   input wire logic i_wp,
   input wire logic [23:0] o_dev_id
);
   logic scl_q, sda_q, rd_q, miss_q;
   logic [3:0] cnt_q, nb_q;
   logic [7:0] sh_q;
   wire logic st = scl_q && i_scl && sda_q && !i_sda;
   wire logic sp = scl_q && i_scl && !sda_q && i_sda;
   wire logic [7:0] by = {sh_q[6:0], i_sda};
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         {rd_q, miss_q, cnt_q, nb_q, sh_q} <= '0;
      end else begin
         scl_q <= i_scl;
         sda_q <= i_sda;
         if (st) begin
            {miss_q, cnt_q, nb_q} <= '0;
         end else if (!scl_q && i_scl) begin
            sh_q <= by;
            cnt_q <= (cnt_q == I2CFR_ACK_SLOT) ? I2CFR_CNT_RST : cnt_q + 4'h1;
            if (cnt_q == I2CFR_ACK_SLOT && nb_q != 4'hf) nb_q <= nb_q + 4'h1;
            if (cnt_q == 4'h7 && nb_q == 4'h0) begin
               rd_q <= i_sda;
               miss_q <= by[7:1] != {I2CFR_TYPE_CODE, i_dev_sel};
            end
         end
      end
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   property p_low; o_sda_o == 1'b0; endproperty
   a_low: assert property (p_low) else $error("sda driven high");
   property p_rise; $rose(o_sda_oe) |-> !i_scl; endproperty
   a_rise: assert property (p_rise) else $error("sda pulled in high phase");
   property p_hold; i_scl && scl_q && $changed(o_sda_oe) |-> !o_sda_oe; endproperty
   a_hold: assert property (p_hold) else $error("sda moved in high phase");
   property p_id; !$past(i_sys_rst) |-> o_dev_id == I2CFR_DEV_ID; endproperty
   a_id: assert property (p_id) else $error("bad id value");
   property p_stop; sp |-> ##[0:6] !o_sda_oe; endproperty
   a_stop: assert property (p_stop) else $error("stop not released");
   property p_start; st |-> ##[0:6] !o_sda_oe; endproperty
   a_start: assert property (p_start) else $error("start not released");
   property p_sel; miss_q |-> !o_sda_oe; endproperty
   a_sel: assert property (p_sel) else $error("answered foreign address");
   property p_slot; (nb_q == 4'h0 || !rd_q) && $rose(o_sda_oe) |-> cnt_q == I2CFR_ACK_SLOT;
   endproperty
   a_slot: assert property (p_slot) else $error("ack outside slot");
endmodule
bind i2cfr_slave i2cfr_chk u_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_scl(i_scl),
   .i_sda(i_sda), .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe), .i_dev_sel(i_dev_sel),
   .i_wp(i_wp), .o_dev_id(o_dev_id));
`default_nettype wire

// ---- verification/i2cfr_master.sv ----
// i2cfr_master: behavioural bus master, owns the serial clock
// assumes the bench resolves sda with a pull-up
`timescale 1ns/1ps
`default_nettype none
module i2cfr_master (
   // serial bus
   output var logic o_scl,
   output var logic o_sda_low,
   input wire logic i_sda
);
   localparam int Q = 18;
   initial begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
   end
   task automatic xbit(input logic b, output logic r);
      o_sda_low = !b;
      #Q o_scl = 1'b1;
      #Q r = i_sda;
      #Q o_scl = 1'b0;
      #Q;
   endtask
   task automatic start();
      o_sda_low = 1'b0;
      #Q o_scl = 1'b1;
      #Q o_sda_low = 1'b1;
      #Q o_scl = 1'b0;
      #Q;
   endtask
   task automatic stop();
      o_sda_low = 1'b1;
      #Q o_scl = 1'b1;
      #Q o_sda_low = 1'b0;
      #(2 * Q);
   endtask
   task automatic xbyte(input logic [7:0] d, input logic mack, output logic [7:0] q,
      output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) xbit(d[i], q[i]);
      xbit(!mack, r);
      ack = !r;
   endtask
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
// testbench: self-checking bench for i2cfr_slave against a memory model
// assumes sda has a pull-up and both parties only pull it low
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_errors++; \
   $display("Error %0t: got %h expected %h", $time, a, e); end end
module testbench
   import i2cfr_pkg::*;
;
   logic i_clk = 1'b0, i_sys_rst = 1'b1, i_wp = 1'b0, scl, sda_low, o_sda_o, o_sda_oe, ak;
   logic [2:0] i_dev_sel = 3'h0;
   logic [7:0] q;
   logic [23:0] o_dev_id;
   logic [7:0] mem [int];
   int n_errors = 0, n_tests = 0, lat = 0, a;
   wire logic sda = (o_sda_oe ? o_sda_o : 1'b1) & !sda_low;
   i2cfr_master m (.o_scl(scl), .o_sda_low(sda_low), .i_sda(sda));
   i2cfr_slave dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_scl(scl), .i_sda(sda),
      .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe), .i_dev_sel(i_dev_sel), .i_wp(i_wp),
      .o_dev_id(o_dev_id));
   initial begin
      forever #2.5 i_clk = !i_clk;
   end
   task automatic end_sim();
      $display("errors %0d tests %0d", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic send(input logic [7:0] d, input logic e);
      m.xbyte(d, 1'b0, q, ak);
      `CHK(ak, e)
   endtask
   task automatic nack(input logic [7:0] d);
      m.start();
      send(d, 1'b0);
      m.stop();
   endtask
   task automatic hdr(input int adr);
      m.start();
      send({I2CFR_TYPE_CODE, i_dev_sel, 1'b0}, 1'b1);
      send({1'($urandom), adr[14:8]}, 1'b1);
      send(adr[7:0], 1'b1);
      lat = adr;
   endtask
   task automatic wr(input int adr, input int n);
      logic [7:0] d;
      hdr(adr);
      for (int k = 0; k < n; k++) begin
         d = 8'($urandom);
         send(d, 1'b1);
         if (!i_wp) mem[lat] = d;
         lat = (lat + 1) % I2CFR_MEM_DEPTH;
      end
      m.stop();
   endtask
   task automatic rd(input int adr, input int n);
      hdr(adr);
      m.start();
      send({I2CFR_TYPE_CODE, i_dev_sel, I2CFR_RW_READ}, 1'b1);
      for (int k = 0; k < n; k++) begin
         m.xbyte(8'hff, k < n - 1, q, ak);
         if (mem.exists(lat)) `CHK(q, mem[lat])
         lat = (lat + 1) % I2CFR_MEM_DEPTH;
      end
      m.stop();
   endtask
   initial begin
      #250000;
      n_errors++;
      end_sim();
   end
   initial begin
      void'($urandom(32'h538d));
      repeat (3) @(posedge i_clk);
      @(negedge i_clk) i_sys_rst = 1'b0;
      @(negedge i_clk) `CHK(o_dev_id, I2CFR_DEV_ID)
      for (int s = 0; s < 8; s++) begin
         @(negedge i_clk) i_dev_sel = 3'(s);
         a = $urandom % I2CFR_MEM_DEPTH;
         wr(a, 2);
         rd(a, 2);
      end
      nack({I2CFR_TYPE_CODE, ~i_dev_sel, 1'b0});
      nack(8'h5e);
      nack(8'h0f);
      wr(32'h7fff, 3);
      rd(32'h7fff, 3);
      @(negedge i_clk) i_wp = 1'b1;
      wr(32'h7fff, 2);
      rd(32'h7fff, 2);
      @(negedge i_clk) i_wp = 1'b0;
      wr(5, 1);
      hdr(5);
      for (int i = 0; i < 4; i++) m.xbit(1'($urandom), ak);
      m.stop();
      rd(5, 1);
      end_sim();
   end
endmodule
`default_nettype wire
